// >>> core/mch_host_port.sv
// Contract
// - Chip select goes active on host I/O read or write to data or command port.
// - Chip select enables both the host data buffer and the embedded controller.
// - Address enable high (DMA cycle) forces chip select inactive.
// - Controller clock is the block clock halved by a toggling flip-flop.
// - Controller reset is system reset ORed with the reset latch.
// - Host write to reset-assert port sets the reset latch.
// - Host write to reset-release port clears the reset latch.
// - Interrupt request line raised when the controller has data ready.
// - Filtered pointer inputs appear on seven consecutive controller port-one bits.
// - Calendar lines reach controller on one port-one bit, five port-two bits.
// - Calendar power failure indication is delivered to the controller.
// - Every pointer input transition held 20 clocks or more, one tick of motion, passes through unmerged.
// - Pointer bit order kept so positive x is right, positive y toward user.
// - Calendar minute, hour, day, month traffic passes unaltered over its lines.
// - Data delivery by interrupt per byte, interrupt then poll, or poll only.
// - Host read of command port returns the status byte.
// - Status bit 0 is outbound byte pending, bit 1 inbound byte pending.
// - Command port write delivers the byte and sets the command flag, bit 3.
// - Status bits 4 to 6 show buttons up, bit 7 calendar power failure.
`timescale 1ns/1ps
module mch_host_port
  import mch_pkg::*;
#(
  parameter int IB_DEPTH = 2
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [9:0]  bus_addr,
  input  wire logic [7:0]  bus_data_in,
  output logic [7:0]       bus_data_out,
  output logic             bus_data_oe_n,
  input  wire logic        bus_ior_n,
  input  wire logic        bus_iow_n,
  input  wire logic        bus_aen,
  input  wire logic        bus_sys_reset,
  output logic             bus_irq3,
  output logic             chip_select,
  output logic             ctrl_select,
  output logic             ctrl_clock,
  output logic             ctrl_reset,
  input  wire logic [7:0]  ctrl_ob_data,
  input  wire logic        ctrl_ob_load,
  input  wire logic        ctrl_irq_req,
  output logic [7:0]       ctrl_ib_data,
  output logic             ctrl_ib_cmd,
  output logic             ctrl_ib_valid,
  input  wire logic        ctrl_ib_ready,
  input  wire logic        ctrl_cmd_flag_clear,
  input  wire logic [2:0]  ctrl_button_up,
  output logic [7:0]       ctrl_port1_in,
  output logic [7:0]       ctrl_port2_in,
  input  wire logic [3:0]  ctrl_port2_out,
  input  wire logic        ctrl_cal_a_out,
  input  wire logic        ctrl_cal_a_drive,
  input  wire logic [6:0]  pointer_input_bits,
  input  wire logic        calendar_link_bit_a_in,
  output logic             calendar_link_bit_a_out,
  output logic             calendar_link_bit_a_oe_n,
  output logic [3:0]       calendar_link_bits_b,
  input  wire logic        calendar_link_bit_c
);

  generate
    if (IB_DEPTH < 2) begin : g_check
      $error("mch_host_port needs IB_DEPTH of at least 2");
    end
  endgenerate

  typedef struct packed {
    mch_bus_e                  bus;
    logic [PIN_W-1:0]          s1;
    logic [PIN_W-1:0]          s2;
    logic                      sel;
    logic                      drive;
    logic [7:0]                rdata;
    logic [9:0]                waddr;
    logic [7:0]                wdata;
    logic                      outbound_byte_pending;
    logic [7:0]                ob_data;
    logic                      f1;
    logic                      rst_latch;
    logic                      push;
    logic [IB_W-1:0]           push_word;
    logic                      div;
    logic                      irq;
    logic                      cres;
    logic [6:0]                filt;
    logic [6:0][FLT_W-1:0]     fcnt;
    logic [7:0]                port1;
    logic [7:0]                port2;
    logic [3:0]                bits_b;
    logic                      cal_a_out;
    logic                      cal_a_oe_n;
  } mch_port_s;

  mch_port_s       st;
  mch_port_s       next_st;
  logic            fifo_in_ready;
  logic [IB_W-1:0] fifo_out_data;
  logic [9:0]      addr_s;
  logic            ior_s;
  logic            iow_s;
  logic            aen_s;
  logic            inbound_byte_pending;
  logic [7:0]      status;

  // Data or command/status port hit, DMA cycles excluded
  function automatic logic port_hit(input logic [9:0] a, input logic aen);
    port_hit = !aen && (a == DATA_PORT || a == CMD_STATUS_PORT);
  endfunction

  mch_fifo #(
    .WIDTH (IB_W),
    .DEPTH (IB_DEPTH)
  ) u_inbound (
    .clock     (clock),
    .reset     (reset),
    .in_data   (st.push_word),
    .in_valid  (st.push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (ctrl_ib_valid),
    .out_ready (ctrl_ib_ready)
  );

  assign ctrl_ib_data = fifo_out_data[7:0];
  assign ctrl_ib_cmd  = fifo_out_data[8];

  // Decisions only read the second synchroniser stage
  assign addr_s = st.s2[PIN_ADDR +: ADDR_W];
  assign ior_s  = !st.s2[PIN_IOR_N];
  assign iow_s  = !st.s2[PIN_IOW_N];
  assign aen_s  = st.s2[PIN_AEN];
  assign inbound_byte_pending    = ctrl_ib_valid;

  always_comb begin
    status              = RESET_BYTE;
    status[ST_OUTBOUND] = st.outbound_byte_pending;
    status[ST_INBOUND]  = inbound_byte_pending;
    status[ST_UNUSED]   = 1'b0;
    status[ST_COMMAND]  = st.f1;
    status[ST_BUTTON0 +: 3] = ctrl_button_up;
    status[ST_PWRFAIL]  = st.s2[PIN_CAL_C];
  end

  always_comb begin
    next_st      = st;
    next_st.s1   = {bus_sys_reset, calendar_link_bit_c,
                    calendar_link_bit_a_in, pointer_input_bits,
                    bus_aen, bus_iow_n, bus_ior_n, bus_data_in, bus_addr};
    next_st.s2   = st.s1;
    next_st.push = 1'b0;
    next_st.div  = !st.div;

    // Controller fills the outbound byte; its load beats a host read
    if (ctrl_ob_load) begin
      next_st.ob_data = ctrl_ob_data;
    end
    if (ctrl_cmd_flag_clear) begin
      next_st.f1 = 1'b0;
    end

    case (st.bus)
      MCH_IDLE: begin
        next_st.sel   = 1'b0;
        next_st.drive = 1'b0;
        if (ior_s && !iow_s) begin
          next_st.bus = MCH_READ;
          if (port_hit(addr_s, aen_s)) begin
            next_st.sel   = 1'b1;
            next_st.drive = 1'b1;
            if (addr_s == CMD_STATUS_PORT) begin
              next_st.rdata = status;
            end else begin
              next_st.rdata = st.ob_data;
              next_st.outbound_byte_pending   = 1'b0;
            end
          end
        end else if (iow_s && !ior_s) begin
          next_st.bus   = MCH_WRITE;
          next_st.sel   = port_hit(addr_s, aen_s);
          next_st.waddr = addr_s;
          next_st.wdata = st.s2[PIN_DATA +: 8];
        end
      end
      MCH_READ: begin
        if (aen_s) begin
          next_st.sel   = 1'b0;
          next_st.drive = 1'b0;
        end
        if (!ior_s) begin
          next_st.bus   = MCH_IDLE;
          next_st.sel   = 1'b0;
          next_st.drive = 1'b0;
        end
      end
      MCH_WRITE: begin
        if (aen_s) begin
          next_st.sel = 1'b0;
        end
        if (iow_s) begin
          // Data settles late on the bus, so keep sampling until release
          next_st.wdata = st.s2[PIN_DATA +: 8];
        end else begin
          next_st.bus = MCH_IDLE;
          next_st.sel = 1'b0;
          if (st.sel) begin
            next_st.push      = 1'b1;
            next_st.push_word = {st.waddr == CMD_STATUS_PORT, st.wdata};
            if (st.waddr == CMD_STATUS_PORT) begin
              next_st.f1 = 1'b1;
            end else if (!ctrl_cmd_flag_clear) begin
              next_st.f1 = 1'b0;
            end
          end else if (!aen_s && st.waddr == RESET_ASSERT) begin
            next_st.rst_latch = 1'b1;
          end else if (!aen_s && st.waddr == RESET_RELEASE) begin
            next_st.rst_latch = 1'b0;
          end
        end
      end
      default: begin
        next_st.bus   = MCH_IDLE;
        next_st.sel   = 1'b0;
        next_st.drive = 1'b0;
      end
    endcase

    if (ctrl_ob_load) begin
      next_st.outbound_byte_pending = 1'b1;
    end

    // Interrupt follows the controller request only while a byte waits
    next_st.irq  = ctrl_irq_req && next_st.outbound_byte_pending;
    next_st.cres = st.s2[PIN_SYSRST] || next_st.rst_latch;

    // Glitch filter stands in for the RC network and Schmitt stage
    for (int i = 0; i < 7; i++) begin
      if (st.s2[PIN_POINTER + i] == st.filt[i]) begin
        next_st.fcnt[i] = '0;
      end else if (st.fcnt[i] == FLT_W'(FILTER_CYCLES - 1)) begin
        next_st.filt[i] = st.s2[PIN_POINTER + i];
        next_st.fcnt[i] = '0;
      end else begin
        next_st.fcnt[i] = st.fcnt[i] + FLT_W'(1);
      end
    end

    // Pointer bits keep their pin order; the controller owns the sense
    next_st.port1 = {st.s2[PIN_CAL_A], st.filt};
    next_st.port2 = {st.s2[PIN_CAL_C], 3'b000, st.bits_b};
    next_st.bits_b     = ctrl_port2_out;
    next_st.cal_a_out  = ctrl_cal_a_out;
    next_st.cal_a_oe_n = !ctrl_cal_a_drive;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st            <= '0;
      st.bus        <= MCH_IDLE;
      st.s1[PIN_IOR_N] <= 1'b1;
      st.s1[PIN_IOW_N] <= 1'b1;
      st.s2[PIN_IOR_N] <= 1'b1;
      st.s2[PIN_IOW_N] <= 1'b1;
      st.rst_latch  <= RESET_LATCH0;
      st.cres       <= 1'b1;
      st.cal_a_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Refused write: a full inbound buffer drops the word, pending stays set
  logic unused_ready;
  assign unused_ready = fifo_in_ready;

  assign bus_data_out             = st.rdata;
  assign bus_data_oe_n            = !st.drive;
  assign bus_irq3                 = st.irq;
  assign chip_select              = st.sel;
  assign ctrl_select              = st.sel;
  assign ctrl_clock               = st.div;
  assign ctrl_reset               = st.cres;
  assign ctrl_port1_in            = st.port1;
  assign ctrl_port2_in            = st.port2;
  assign calendar_link_bit_a_out  = st.cal_a_out;
  assign calendar_link_bit_a_oe_n = st.cal_a_oe_n;
  assign calendar_link_bits_b     = st.bits_b;

endmodule

// >>> include/mch_pkg.sv
package mch_pkg;

  // Host I/O port map, 10-bit I/O decode
  localparam int          ADDR_W          = 10;
  localparam logic [9:0]  DATA_PORT       = 10'h2FC;
  localparam logic [9:0]  RESET_RELEASE   = 10'h2FD;
  localparam logic [9:0]  CMD_STATUS_PORT = 10'h2FE;
  localparam logic [9:0]  RESET_ASSERT    = 10'h2FF;

  // Status byte layout
  localparam int ST_OUTBOUND = 0;
  localparam int ST_INBOUND  = 1;
  localparam int ST_UNUSED   = 2;
  localparam int ST_COMMAND  = 3;
  localparam int ST_BUTTON0  = 4;
  localparam int ST_PWRFAIL  = 7;

  // Synchroniser vector layout
  localparam int PIN_ADDR    = 0;
  localparam int PIN_DATA    = 10;
  localparam int PIN_IOR_N   = 18;
  localparam int PIN_IOW_N   = 19;
  localparam int PIN_AEN     = 20;
  localparam int PIN_POINTER = 21;
  localparam int PIN_CAL_A   = 28;
  localparam int PIN_CAL_C   = 29;
  localparam int PIN_SYSRST  = 30;
  localparam int PIN_W       = 31;

  // Values after reset
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic       RESET_LATCH0 = 1'b0;

  // Pointer input glitch filter
  localparam int CLOCK_MHZ      = 20;
  localparam int FILTER_TIME_NS = 1000;
  localparam int FILTER_CYCLES  = (FILTER_TIME_NS * CLOCK_MHZ + 999) / 1000;
  localparam int FLT_W          = $clog2(FILTER_CYCLES + 1);

  // Inbound word: command marker above the byte
  localparam int IB_W = 9;

  typedef enum logic [2:0] {
    MCH_IDLE  = 3'b001,
    MCH_READ  = 3'b010,
    MCH_WRITE = 3'b100
  } mch_bus_e;

endpackage

// >>> core/mch_fifo.sv
`timescale 1ns/1ps
module mch_fifo
  import mch_pkg::*;
#(
  parameter int WIDTH = IB_W,
  parameter int DEPTH = 2
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || WIDTH < 1) begin : g_check
      $error("mch_fifo needs DEPTH of at least 2 and WIDTH of at least 1");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               count;
  } mch_fifo_s;

  mch_fifo_s st;
  mch_fifo_s next_st;
  logic      push;
  logic      pop;

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      next_ptr = '0;
    end else begin
      next_ptr = p + PW'(1);
    end
  endfunction

  assign in_ready  = (st.count != CW'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data  = st.mem[st.rp];

  always_comb begin
    next_st = st;
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp         = next_ptr(st.wp);
    end
    if (pop) begin
      next_st.rp = next_ptr(st.rp);
    end
    if (push && !pop) begin
      next_st.count = st.count + CW'(1);
    end else if (pop && !push) begin
      next_st.count = st.count - CW'(1);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// >>> verif/mch_host_model.sv
`timescale 1ns/1ps
module mch_host_model
  import mch_pkg::*;
(
  input  wire logic       clock,
  output logic [9:0]      addr,
  output logic [7:0]      data,
  output logic            ior_n,
  output logic            iow_n,
  output logic            aen,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_oe_n
);
  initial begin
    addr = 10'h000;
    data = 8'h00;
    ior_n = 1'h1;
    iow_n = 1'h1;
    aen = 1'h0;
  end
  // Idle gap after each cycle so the synced strobe is seen high
  task automatic io(input logic wr, input logic [9:0] a,
                    input logic [7:0] d, input logic dma,
                    output logic [7:0] q, output logic drv);
    q = 8'h00;
    drv = 1'h0;
    @(negedge clock);
    addr = a;
    data = d;
    aen = dma;
    ior_n = wr;
    iow_n = !wr;
    repeat (6) begin
      @(posedge clock);
      #1;
      if (rd_oe_n === 1'h0) begin
        drv = 1'h1;
        q = rd_data;
      end
    end
    @(negedge clock);
    ior_n = 1'h1;
    iow_n = 1'h1;
    // Released lines must not echo the last byte
    data = ~d;
    repeat (4) @(negedge clock);
    aen = 1'h0;
  endtask
endmodule

// >>> verif/mch_host_port_assertions.sv
`timescale 1ns/1ps
module mch_host_port_assertions
  import mch_pkg::*;
(
  input wire logic       clock,
  input wire logic       reset,
  input wire logic [9:0] bus_addr,
  input wire logic [7:0] bus_data_out,
  input wire logic       bus_data_oe_n,
  input wire logic       bus_ior_n,
  input wire logic       bus_iow_n,
  input wire logic       bus_aen,
  input wire logic       bus_sys_reset,
  input wire logic       bus_irq3,
  input wire logic       chip_select,
  input wire logic       ctrl_select,
  input wire logic       ctrl_clock,
  input wire logic       ctrl_reset,
  input wire logic       ctrl_ob_load,
  input wire logic       ctrl_irq_req,
  input wire logic [3:0] ctrl_port2_out,
  input wire logic [3:0] calendar_link_bits_b
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  AST_SEL_PAIR: assert property (chip_select == ctrl_select)
    else $error("select outputs differ");
  AST_CLK_HALF: assert property (1'h1 |=> ctrl_clock != $past(ctrl_clock))
    else $error("controller clock did not toggle");
  AST_DMA_BLOCK: assert property (bus_aen [*4] |-> !chip_select)
    else $error("select during dma");
  AST_IDLE_DROP: assert property ((bus_ior_n && bus_iow_n) [*4] |-> !chip_select)
    else $error("select without strobe");
  AST_DRIVE_READ: assert property (!bus_data_oe_n |-> chip_select && !$past(bus_ior_n, 3))
    else $error("data driven outside a decoded read");
  AST_SYS_RESET: assert property (bus_sys_reset [*4] |-> ctrl_reset)
    else $error("system reset not passed on");
  AST_IRQ_CAUSE: assert property (bus_irq3 |-> $past(ctrl_irq_req))
    else $error("interrupt without request");
  AST_IRQ_LOAD: assert property (ctrl_ob_load && ctrl_irq_req |-> ##[1:2] bus_irq3)
    else $error("no interrupt after load");
  AST_STATUS_B2: assert property (!bus_data_oe_n && $past(bus_addr, 3) == CMD_STATUS_PORT |-> !bus_data_out[ST_UNUSED])
    else $error("status bit 2 set");
  AST_CAL_B: assert property (calendar_link_bits_b == $past(ctrl_port2_out))
    else $error("calendar lines not copied");
  AST_READ_HIT: assert property ($fell(bus_ior_n) && bus_iow_n && !bus_aen
    && (bus_addr == DATA_PORT || bus_addr == CMD_STATUS_PORT)
    |-> ##3 chip_select && !bus_data_oe_n)
    else $error("decoded read not selected");
  AST_WRITE_HIT: assert property ($fell(bus_iow_n) && bus_ior_n && !bus_aen
    && (bus_addr == DATA_PORT || bus_addr == CMD_STATUS_PORT)
    |-> ##3 chip_select && bus_data_oe_n)
    else $error("decoded write not selected");
  cover property (!bus_data_oe_n);
  cover property ($rose(bus_irq3));
  cover property ($rose(ctrl_reset));
endmodule
bind mch_host_port mch_host_port_assertions chk_u (.*);

// >>> verif/mch_host_port_test.sv
`timescale 1ns/1ps
module mch_host_port_test
  import mch_pkg::*;
;
  logic       clock = 1'h0, reset = 1'h1, bus_sys_reset = 1'h0;
  logic       ctrl_ob_load = 1'h0, ctrl_irq_req = 1'h0;
  logic       ctrl_ib_ready = 1'h0, ctrl_cmd_flag_clear = 1'h0;
  logic       ctrl_cal_a_drive = 1'h0, ctrl_cal_a_out = 1'h0;
  logic       cal_a_tb = 1'h0, calendar_link_bit_c = 1'h1;
  logic [7:0] ctrl_ob_data = 8'h00;
  logic [6:0] pointer_input_bits = 7'h00;
  logic [3:0] ctrl_port2_out = 4'h0;
  logic [2:0] ctrl_button_up = 3'h5;
  logic [9:0] bus_addr;
  logic [7:0] hdata, bus_data_in, bus_data_out, ctrl_ib_data, q;
  logic [7:0] ctrl_port1_in, ctrl_port2_in;
  logic [3:0] calendar_link_bits_b;
  logic       bus_ior_n, bus_iow_n, bus_aen, bus_data_oe_n, bus_irq3, drv;
  logic       chip_select, ctrl_select, ctrl_clock, ctrl_reset, ctrl_ib_cmd;
  logic       ctrl_ib_valid, calendar_link_bit_a_in, calendar_link_bit_a_out;
  logic       calendar_link_bit_a_oe_n;
  int         n_fail = 0, num_checks = 0, cyc = 0;

  assign bus_data_in = !bus_data_oe_n ? bus_data_out : hdata;
  assign calendar_link_bit_a_in =
    !calendar_link_bit_a_oe_n ? calendar_link_bit_a_out : cal_a_tb;

  mch_host_port dut_u (.*);
  mch_host_model host_u (.clock(clock), .addr(bus_addr), .data(hdata),
    .ior_n(bus_ior_n), .iow_n(bus_iow_n), .aen(bus_aen),
    .rd_data(bus_data_out), .rd_oe_n(bus_data_oe_n));

  always #25 clock = ~clock;

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Run is a few hundred cycles; ceiling leaves wide margin
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [9:0] a, input logic dma);
    host_u.io(1'h0, a, 8'h00, dma, q, drv);
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    host_u.io(1'h1, a, d, 1'h0, q, drv);
  endtask

  task automatic t_status();
    rd(CMD_STATUS_PORT, 1'h0);
    chk({drv, q}, 9'h1D0);
    ctrl_button_up = 3'h2;
    calendar_link_bit_c = 1'h0;
    rd(CMD_STATUS_PORT, 1'h0);
    chk({drv, q}, 9'h120);
    rd(CMD_STATUS_PORT, 1'h1);
    chk(9'(drv), 9'h000);
    rd(RESET_ASSERT, 1'h0);
    chk(9'(drv), 9'h000);
    rd(10'h2F0, 1'h0);
    chk(9'(drv), 9'h000);
  endtask

  task automatic t_inbound();
    // Header of a read-time command, sent as a single command byte
    wr(CMD_STATUS_PORT, 8'h02);
    rd(CMD_STATUS_PORT, 1'h0);
    chk(9'(q[3:0]), 9'h00A);
    wr(DATA_PORT, 8'h3C);
    rd(CMD_STATUS_PORT, 1'h0);
    chk(9'(q[3:0]), 9'h002);
    // Buffer full: this word is dropped
    wr(DATA_PORT, 8'hE1);
    chk({ctrl_ib_cmd, ctrl_ib_data}, 9'h102);
    ctrl_ib_ready = 1'h1;
    @(negedge clock);
    chk({ctrl_ib_cmd, ctrl_ib_data}, 9'h03C);
    @(negedge clock);
    ctrl_ib_ready = 1'h0;
    chk(9'(ctrl_ib_valid), 9'h000);
  endtask

  task automatic t_outbound();
    ctrl_irq_req = 1'h1;
    ctrl_ob_data = 8'h5A;
    ctrl_ob_load = 1'h1;
    @(negedge clock);
    ctrl_ob_load = 1'h0;
    @(negedge clock);
    chk(9'(bus_irq3), 9'h001);
    rd(CMD_STATUS_PORT, 1'h0);
    chk(9'(q[0]), 9'h001);
    rd(DATA_PORT, 1'h0);
    chk({drv, q}, 9'h15A);
    rd(CMD_STATUS_PORT, 1'h0);
    chk({bus_irq3, q[0]}, 9'h000);
    ctrl_irq_req = 1'h0;
  endtask

  task automatic t_latch();
    wr(RESET_ASSERT, 8'h00);
    chk({ctrl_ib_valid, ctrl_reset}, 9'h001);
    wr(RESET_RELEASE, 8'h00);
    chk({ctrl_ib_valid, ctrl_reset}, 9'h000);
    bus_sys_reset = 1'h1;
    repeat (5) @(negedge clock);
    chk(9'(ctrl_reset), 9'h001);
    bus_sys_reset = 1'h0;
    repeat (5) @(negedge clock);
    chk(9'(ctrl_reset), 9'h000);
  endtask

  task automatic t_pins();
    pointer_input_bits = 7'h55;
    ctrl_port2_out = 4'hA;
    cal_a_tb = 1'h1;
    calendar_link_bit_c = 1'h1;
    repeat (30) @(negedge clock);
    chk(9'(ctrl_port1_in), 9'h0D5);
    chk({calendar_link_bits_b, ctrl_port2_in[7:4]}, 9'h0A8);
    // Short glitch must be filtered, the held value must stay
    pointer_input_bits = 7'h2A;
    repeat (5) @(negedge clock);
    pointer_input_bits = 7'h55;
    repeat (30) @(negedge clock);
    chk(9'(ctrl_port1_in[6:0]), 9'h055);
    ctrl_cal_a_drive = 1'h1;
    repeat (6) @(negedge clock);
    chk({calendar_link_bit_a_oe_n, ctrl_port1_in[7]}, 9'h000);
  endtask

  initial begin
    repeat (20) @(negedge clock);
    reset = 1'h0;
    repeat (3) @(negedge clock);
    t_status();
    t_inbound();
    t_outbound();
    t_latch();
    t_pins();
    report_and_stop();
  end
endmodule
